// ==== hw/rx_pause_params.svh ====
// Offsets, field positions, reset values and frame constants of the receive pause checker
`ifndef RX_PAUSE_PARAMS_SVH
`define RX_PAUSE_PARAMS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_RXEN 8'h04
`define REG_UCAST_LO 8'h08
`define REG_UCAST_HI 8'h0c
`define REG_SRC_LO 8'h10
`define REG_SRC_HI 8'h14
`define REG_STATUS 8'h18
`define REG_DROPS 8'h1c
`define REG_QUANTA0 8'h20
`define REG_QUANTA8 8'h40

// Control register field positions
`define CTRL_GLB_EN 0
`define CTRL_PRI_EN 1
`define CTRL_G_MC 2
`define CTRL_G_UC 3
`define CTRL_G_SA 4
`define CTRL_G_ET 5
`define CTRL_G_OP 6
`define CTRL_P_MC 7
`define CTRL_P_UC 8
`define CTRL_P_SA 9
`define CTRL_P_ET 10
`define CTRL_P_OP 11

// Reset values
`define CTRL_RST 12'hce7
`define RXEN_RST 9'h1ff
`define ADDR_RST 48'h0000_0000_0000

// Frame constants
`define PAUSE_MCAST 48'h0180_c200_0001
`define CTL_ETYPE 16'h8808
`define OPC_GLOBAL 16'h0001
`define OPC_PRIO 16'h0101
`define OPC_PRIO_BIT 8
`define LAST_HDR_WORD 3'h4
`define WORD_CNT_MAX 3'h5
`endif

// ==== hw/rx_pause_pkg.sv ====
// Types shared by the receive pause checker modules
package rx_pause_pkg;
  typedef logic [15:0] quanta_t;
  typedef logic [8:0] class_vec_t;
  typedef logic [47:0] mac_addr_t;
  typedef quanta_t [8:0] quanta_arr_t;
  typedef enum logic [1:0] {
    KIND_GLOBAL = 2'b01,
    KIND_PRIO = 2'b10
  } frame_kind_t;
endpackage

// ==== hw/pause_frame_if.sv ====
// Parsed header fields of one received frame
`timescale 1ns/10ps
interface pause_frame_if;
  import rx_pause_pkg::*;
  logic done;
  mac_addr_t da;
  mac_addr_t sa;
  logic [15:0] etype;
  logic [15:0] opcode;
  logic [191:0] payload;
  modport cap (output done, output da, output sa, output etype, output opcode,
    output payload);
  modport chk (input done, input da, input sa, input etype, input opcode,
    input payload);
endinterface

// ==== hw/pause_hdr_capture.sv ====
// Header capture from the 64-bit receive word stream
`timescale 1ns/10ps
`include "rx_pause_params.svh"
module pause_hdr_capture import rx_pause_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Receive words, first byte in the top lane
  input wire logic valid,
  input wire logic sop,
  input wire logic eop,
  input wire logic err,
  input wire logic [63:0] data,
  // Parsed fields
  pause_frame_if.cap frm
);
  logic [2:0] cnt_q;
  logic [2:0] cur;

  // Word index of the current beat; start of frame restarts it
  assign cur = sop ? 3'h0 : cnt_q;

  // Word counter, saturating past the header
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else if (valid) begin
      if (eop) begin
        cnt_q <= 3'h0;
      end else if (cur != `WORD_CNT_MAX) begin
        cnt_q <= cur + 3'h1;
      end
    end
  end

  // Field capture; fields stay until the next frame overwrites them
  always_ff @(posedge clk) begin
    if (valid) begin
      unique case (cur)
        3'h0: begin
          frm.da <= data[63:16];
          frm.sa[47:32] <= data[15:0];
        end
        3'h1: begin
          frm.sa[31:0] <= data[63:32];
          frm.etype <= data[31:16];
          frm.opcode <= data[15:0];
        end
        3'h2: frm.payload[191:128] <= data;
        3'h3: frm.payload[127:64] <= data;
        3'h4: frm.payload[63:0] <= data;
        default: ;
      endcase
    end
  end

  // Frame end pulse; errored or runt frames never reach the checks
  always_ff @(posedge clk) begin
    if (rst) begin
      frm.done <= 1'b0;
    end else begin
      frm.done <= valid & eop & ~err & (cur >= `LAST_HDR_WORD);
    end
  end
endmodule

// ==== hw/pause_class_slot.sv ====
// Request, valid and quanta holder for one pause class
`timescale 1ns/10ps
module pause_class_slot import rx_pause_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Accepted pause for this class
  input wire logic set,
  input wire quanta_t quanta_in,
  // User acknowledge
  input wire logic ack,
  // Report
  output logic req_q,
  output logic valid_q,
  output quanta_t quanta_q
);
  // Request holds until acknowledged; a new pause beats a same-cycle ack
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= 1'b0;
    end else if (set) begin
      req_q <= 1'b1;
    end else if (ack) begin
      req_q <= 1'b0;
    end
  end

  // Valid pulses once, with the quanta it qualifies
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= set;
    end
  end

  // Quanta changes only for an accepted frame
  always_ff @(posedge clk) begin
    if (rst) begin
      quanta_q <= 16'h0000;
    end else if (set) begin
      quanta_q <= quanta_in;
    end
  end
endmodule

// ==== hw/rx_pause_check.sv ====
// Receive pause frame checker and reporter with APB control
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "rx_pause_params.svh"
module rx_pause_check import rx_pause_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Receive word stream
  input wire logic RX_VALID,
  input wire logic RX_SOP,
  input wire logic RX_EOP,
  input wire logic RX_ERR,
  input wire logic [63:0] RX_DATA,
  // Pause report to user logic
  output logic [8:0] RX_PAUSE_REQ,
  input wire logic [8:0] RX_PAUSE_ACK,
  output logic [8:0] RX_PAUSE_VALID,
  // Received quanta per class
  output quanta_t RX_QUANTA_PRIO0,
  output quanta_t RX_QUANTA_PRIO1,
  output quanta_t RX_QUANTA_PRIO2,
  output quanta_t RX_QUANTA_PRIO3,
  output quanta_t RX_QUANTA_PRIO4,
  output quanta_t RX_QUANTA_PRIO5,
  output quanta_t RX_QUANTA_PRIO6,
  output quanta_t RX_QUANTA_PRIO7,
  output quanta_t RX_QUANTA_GLOBAL
);
  // Software state
  logic [11:0] ctrl_q;
  class_vec_t rxen_q;
  mac_addr_t ucast_q;
  mac_addr_t src_q;
  logic [15:0] drops_q;

  // Bus state
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Bus decode
  logic setup;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd_data;
  logic [3:0] qidx;

  // Frame checks
  frame_kind_t kind;
  logic mc_hit;
  logic uc_hit;
  logic sa_hit;
  logic et_hit;
  logic g_op_hit;
  logic p_op_hit;
  logic g_da_ok;
  logic p_da_ok;
  logic g_ok;
  logic p_ok;
  class_vec_t set_vec;
  quanta_arr_t q_in;

  // Slot outputs
  class_vec_t req_q;
  class_vec_t valid_q;
  quanta_arr_t quanta_q;

  // Parsed header
  pause_frame_if frm ();

  // Byte-lane merge for APB strobes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Header capture from the word stream
  pause_hdr_capture u_cap (
    .clk(REF_CLK),
    .rst(RST),
    .valid(RX_VALID),
    .sop(RX_SOP),
    .eop(RX_EOP),
    .err(RX_ERR),
    .data(RX_DATA),
    .frm(frm.cap)
  );

  // Field comparisons
  assign mc_hit = (frm.da == `PAUSE_MCAST);
  assign uc_hit = (frm.da == ucast_q);
  assign sa_hit = (frm.sa == src_q);
  assign et_hit = (frm.etype == `CTL_ETYPE);
  assign g_op_hit = (frm.opcode == `OPC_GLOBAL);
  assign p_op_hit = (frm.opcode == `OPC_PRIO);

  // Opcode bit 8 sorts the kind so each opcode check stays meaningful
  assign kind = frm.opcode[`OPC_PRIO_BIT] ? KIND_PRIO : KIND_GLOBAL;

  // Destination passes if any enabled address matches, or none is enabled
  assign g_da_ok = ~(ctrl_q[`CTRL_G_MC] | ctrl_q[`CTRL_G_UC])
    | (ctrl_q[`CTRL_G_MC] & mc_hit)
    | (ctrl_q[`CTRL_G_UC] & uc_hit);
  assign p_da_ok = ~(ctrl_q[`CTRL_P_MC] | ctrl_q[`CTRL_P_UC])
    | (ctrl_q[`CTRL_P_MC] & mc_hit)
    | (ctrl_q[`CTRL_P_UC] & uc_hit);

  // Global pause acceptance
  always_comb begin
    g_ok = frm.done & (kind == KIND_GLOBAL);
    g_ok = g_ok & ctrl_q[`CTRL_GLB_EN];
    g_ok = g_ok & g_da_ok;
    g_ok = g_ok & (~ctrl_q[`CTRL_G_SA] | sa_hit);
    g_ok = g_ok & (~ctrl_q[`CTRL_G_ET] | et_hit);
    g_ok = g_ok & (~ctrl_q[`CTRL_G_OP] | g_op_hit);
  end

  // Priority pause acceptance
  always_comb begin
    p_ok = frm.done & (kind == KIND_PRIO);
    p_ok = p_ok & ctrl_q[`CTRL_PRI_EN];
    p_ok = p_ok & p_da_ok;
    p_ok = p_ok & (~ctrl_q[`CTRL_P_SA] | sa_hit);
    p_ok = p_ok & (~ctrl_q[`CTRL_P_ET] | et_hit);
    p_ok = p_ok & (~ctrl_q[`CTRL_P_OP] | p_op_hit);
  end

  // Class set pulses; class enable vector picks the priorities
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      set_vec[i] = p_ok & frm.payload[176 + i];
    end
    set_vec[8] = g_ok;
  end

  // Quanta lanes: global quanta sits where the class vector would be
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      q_in[i] = frm.payload[175 - 16*i -: 16];
    end
    q_in[8] = frm.payload[191:176];
  end

  // One holder per class; the per-class enable is not an input here
  for (genvar c = 0; c < 9; c++) begin : g_slot
    pause_class_slot u_slot (
      .clk(REF_CLK),
      .rst(RST),
      .set(set_vec[c]),
      .quanta_in(q_in[c]),
      .ack(RX_PAUSE_ACK[c]),
      .req_q(req_q[c]),
      .valid_q(valid_q[c]),
      .quanta_q(quanta_q[c])
    );
  end

  // Reporting gated per class; internal state keeps running regardless
  assign RX_PAUSE_REQ = req_q & rxen_q;
  assign RX_PAUSE_VALID = valid_q & rxen_q;

  // Quanta outputs straight from the slot flops
  assign RX_QUANTA_PRIO0 = quanta_q[0];
  assign RX_QUANTA_PRIO1 = quanta_q[1];
  assign RX_QUANTA_PRIO2 = quanta_q[2];
  assign RX_QUANTA_PRIO3 = quanta_q[3];
  assign RX_QUANTA_PRIO4 = quanta_q[4];
  assign RX_QUANTA_PRIO5 = quanta_q[5];
  assign RX_QUANTA_PRIO6 = quanta_q[6];
  assign RX_QUANTA_PRIO7 = quanta_q[7];
  assign RX_QUANTA_GLOBAL = quanta_q[8];

  // Rejected frame counter; saturates rather than wraps
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      drops_q <= 16'h0000;
    end else if (frm.done & ~(g_ok | p_ok) & (drops_q != 16'hffff)) begin
      drops_q <= drops_q + 16'h0001;
    end
  end

  // APB phases
  assign setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign qidx = 4'((PADDR - `REG_QUANTA0) >> 2);

  // Read mux and map check
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = 1'b1;
    unique case (PADDR)
      `REG_CTRL: rd_data[11:0] = ctrl_q;
      `REG_RXEN: rd_data[8:0] = rxen_q;
      `REG_UCAST_LO: rd_data = ucast_q[31:0];
      `REG_UCAST_HI: rd_data[15:0] = ucast_q[47:32];
      `REG_SRC_LO: rd_data = src_q[31:0];
      `REG_SRC_HI: rd_data[15:0] = src_q[47:32];
      `REG_STATUS: rd_data[8:0] = req_q;
      `REG_DROPS: rd_data[15:0] = drops_q;
      default: begin
        if (PADDR >= `REG_QUANTA0 && PADDR <= `REG_QUANTA8
            && PADDR[1:0] == 2'b00) begin
          rd_data[15:0] = quanta_q[qidx];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // Read data and error latched in setup, so access-phase outputs are flops
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= PWRITE ? 32'h0000_0000 : rd_data;
      pslverr_q <= ~mapped;
    end
  end

  // Zero-wait slave
  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;

  // Control and enable writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_q <= `CTRL_RST;
      rxen_q <= `RXEN_RST;
    end else if (wr_acc) begin
      if (PADDR == `REG_CTRL) begin
        ctrl_q <= 12'(lane_merge({20'h00000, ctrl_q}, PWDATA, PSTRB));
      end
      if (PADDR == `REG_RXEN) begin
        rxen_q <= 9'(lane_merge({23'h000000, rxen_q}, PWDATA, PSTRB));
      end
    end
  end

  // Unicast destination address writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ucast_q <= `ADDR_RST;
    end else if (wr_acc) begin
      if (PADDR == `REG_UCAST_LO) begin
        ucast_q[31:0] <= lane_merge(ucast_q[31:0], PWDATA, PSTRB);
      end
      if (PADDR == `REG_UCAST_HI) begin
        ucast_q[47:32] <= 16'(lane_merge({16'h0000, ucast_q[47:32]}, PWDATA, PSTRB));
      end
    end
  end

  // Expected source address writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      src_q <= `ADDR_RST;
    end else if (wr_acc) begin
      if (PADDR == `REG_SRC_LO) begin
        src_q[31:0] <= lane_merge(src_q[31:0], PWDATA, PSTRB);
      end
      if (PADDR == `REG_SRC_HI) begin
        src_q[47:32] <= 16'(lane_merge({16'h0000, src_q[47:32]}, PWDATA, PSTRB));
      end
    end
  end
endmodule

// ==== verification/rx_pause_check_checker.sv ====
// Concurrent checks on the ports of the receive pause checker
`timescale 1ns/10ps
module rx_pause_check_checker import rx_pause_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Receive stream and report
  input wire logic RX_VALID,
  input wire logic RX_EOP,
  input wire logic [8:0] RX_PAUSE_REQ,
  input wire logic [8:0] RX_PAUSE_ACK,
  input wire logic [8:0] RX_PAUSE_VALID,
  input wire quanta_t RX_QUANTA_PRIO0,
  input wire quanta_t RX_QUANTA_GLOBAL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // No frame end now, so two edges on the report must be quiet
  sequence s_quiet;
    !(RX_VALID && RX_EOP) ##1 1'b1;
  endsequence
  property p_quanta_hold;
    s_quiet |=> $stable(RX_QUANTA_PRIO0) && $stable(RX_QUANTA_GLOBAL);
  endproperty
  a_quanta_hold: assert property (p_quanta_hold)
    else $error("quanta changed with no frame end");
  property p_valid_cause;
    s_quiet |=> RX_PAUSE_VALID == 9'h0;
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("valid with no frame end");
  property p_valid_pulse;
    RX_PAUSE_VALID != 9'h0 |=> RX_PAUSE_VALID == 9'h0;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("valid longer than one cycle");
  property p_valid_req;
    (RX_PAUSE_VALID & ~RX_PAUSE_REQ) == 9'h0;
  endproperty
  a_valid_req: assert property (p_valid_req)
    else $error("valid without request");
  // Only an acknowledge or a register write may drop a request
  property p_req_hold;
    ($past(RX_PAUSE_REQ) & ~RX_PAUSE_REQ & ~$past(RX_PAUSE_ACK)) != 9'h0
      |-> $past(PSEL && PENABLE && PWRITE);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped without acknowledge");
  property p_req_rise;
    (RX_PAUSE_REQ & ~$past(RX_PAUSE_REQ) & ~RX_PAUSE_VALID) != 9'h0
      |-> $past(PSEL && PENABLE && PWRITE);
  endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("request rose without valid");
  property p_ack_clear;
    ($past(RX_PAUSE_ACK) & RX_PAUSE_REQ & ~RX_PAUSE_VALID) == 9'h0;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("request kept after acknowledge");
  property p_ready;
    PSEL |-> PREADY;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready low");
  property p_slverr;
    PSEL && PENABLE && PADDR > 8'h40 |-> PSLVERR;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("no error on unmapped address");
endmodule

bind rx_pause_check rx_pause_check_checker u_rx_pause_check_checker (.*);

// ==== verification/user_pause_model.sv ====
// User flow-control logic that acknowledges pause requests
`timescale 1ns/10ps
module user_pause_model import rx_pause_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pause report
  input wire class_vec_t req,
  output class_vec_t ack,
  // Bench control: stall and latency
  input wire logic hold,
  input wire logic [3:0] delay
);
  logic [3:0] wait_q;
  class_vec_t ack_q;
  // Forced low in reset so the design never sees an unknown
  assign ack = ack_q & ~{9{rst}};
  // Acknowledge all shown classes once the latency has run out
  always_ff @(posedge clk) begin
    if (rst || hold || req == 9'h0) begin
      wait_q <= 4'h0;
      ack_q <= 9'h0;
    end else if (wait_q >= delay) begin
      wait_q <= 4'h0;
      ack_q <= req;
    end else begin
      wait_q <= wait_q + 4'h1;
      ack_q <= 9'h0;
    end
  end
endmodule

// ==== verification/rx_pause_check_tb_top.sv ====
// Self-checking bench of the receive pause checker
`timescale 1ns/10ps
`include "rx_pause_params.svh"
module rx_pause_check_tb_top import rx_pause_pkg::*; ;
  logic REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, hold;
  logic RX_VALID, RX_SOP, RX_EOP, RX_ERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [63:0] RX_DATA;
  logic [3:0] dly;
  logic [11:0] ctrl_s;
  class_vec_t RX_PAUSE_REQ, RX_PAUSE_ACK, RX_PAUSE_VALID, acc, rxen_s;
  mac_addr_t ucast_s, src_s;
  quanta_arr_t qm;
  wire quanta_arr_t qo;
  int fails, compares, cyc, drops;
  logic rej;

  rx_pause_check u_rx_pause_check (.*, .PSTRB(4'hf), .RX_QUANTA_PRIO0(qo[0]),
    .RX_QUANTA_PRIO1(qo[1]), .RX_QUANTA_PRIO2(qo[2]), .RX_QUANTA_PRIO3(qo[3]),
    .RX_QUANTA_PRIO4(qo[4]), .RX_QUANTA_PRIO5(qo[5]), .RX_QUANTA_PRIO6(qo[6]),
    .RX_QUANTA_PRIO7(qo[7]), .RX_QUANTA_GLOBAL(qo[8]));
  user_pause_model u_user_pause_model (.clk(REF_CLK), .rst(RST), .req(RX_PAUSE_REQ),
    .ack(RX_PAUSE_ACK), .hold(hold), .delay(dly));

  // Free-running 200 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on ready rather than assuming zero wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // Classes a frame should set under the current settings
  function automatic class_vec_t exp_set(mac_addr_t da, mac_addr_t sa, logic [15:0] et,
      logic [15:0] op, logic [15:0] v);
    logic g;
    int b;
    rej = 1'b1;
    g = !op[8];
    b = g ? 2 : 7;
    if (!ctrl_s[g ? 0 : 1]) return 9'h0;
    if ((ctrl_s[b] | ctrl_s[b+1]) && !(ctrl_s[b] && da == `PAUSE_MCAST)
        && !(ctrl_s[b+1] && da == ucast_s)) return 9'h0;
    if (ctrl_s[b+2] && sa != src_s) return 9'h0;
    if (ctrl_s[b+3] && et != `CTL_ETYPE) return 9'h0;
    if (ctrl_s[b+4] && op != (g ? `OPC_GLOBAL : `OPC_PRIO)) return 9'h0;
    rej = 1'b0;
    return g ? 9'h100 : {1'b0, v[7:0]};
  endfunction

  // Sends a five-word frame and checks the report two edges after its end
  task automatic run(input mac_addr_t da, input mac_addr_t sa, input logic [15:0] et,
      input logic [15:0] op, input logic [15:0] v, input quanta_arr_t q, input logic er);
    logic [63:0] w [5];
    class_vec_t m;
    // Errored frames never reach the checks, so they are not counted as drops
    rej = 1'b0;
    m = er ? 9'h0 : exp_set(da, sa, et, op, v);
    drops += int'(rej);
    w = '{{da, sa[47:32]}, {sa[31:0], et, op}, {v, q[0], q[1], q[2]},
      {q[3], q[4], q[5], q[6]}, {q[7], 48'h0}};
    for (int i = 0; i < 5; i++) begin
      RX_VALID <= 1'b1;
      RX_SOP <= (i == 0);
      RX_EOP <= (i == 4);
      RX_ERR <= er && i == 4;
      RX_DATA <= w[i];
      @(posedge REF_CLK);
    end
    RX_VALID <= 1'b0;
    RX_EOP <= 1'b0;
    RX_ERR <= 1'b0;
    RX_DATA <= ~w[4];
    @(posedge REF_CLK);
    #1;
    chk(32'(RX_PAUSE_VALID), 32'(m & rxen_s));
    acc |= m;
    for (int i = 0; i < 9; i++) begin
      if (m[i]) qm[i] = m[8] ? v : q[i];
      chk(32'(qo[i]), 32'(qm[i]));
    end
    chk(32'(RX_PAUSE_REQ), 32'(acc & rxen_s));
    @(posedge REF_CLK);
  endtask

  // Let the user side acknowledge everything it can see
  task automatic clear_all;
    dly <= 4'($urandom % 4);
    hold <= 1'b0;
    repeat (30) @(posedge REF_CLK);
    hold <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    #1;
    acc &= ~rxen_s;
    chk(32'(RX_PAUSE_REQ), 32'(acc & rxen_s));
    @(posedge REF_CLK);
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    quanta_arr_t q;
    {PSEL, PENABLE, PWRITE, RX_VALID, RX_SOP, RX_EOP, RX_ERR} = 7'h0;
    {PADDR, PWDATA, RX_DATA} = '0;
    RST = 1'b1;
    hold = 1'b1;
    dly = 4'h0;
    {fails, compares, cyc, drops} = '0;
    rej = 1'b0;
    {acc, qm} = '0;
    ctrl_s = 12'hce7;
    rxen_s = 9'h1ff;
    r = $urandom(32'h3988c660);
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    apb(1'b0, `REG_CTRL, 32'h0, r, e);
    chk(r, 32'hce7);
    apb(1'b0, `REG_RXEN, 32'h0, r, e);
    chk(r, 32'h1ff);
    apb(1'b0, 8'h80, 32'h0, r, e);
    chk(32'(e), 32'h1);
    ucast_s = 48'({$urandom, $urandom});
    src_s = 48'({$urandom, $urandom});
    wr(`REG_UCAST_LO, ucast_s[31:0]);
    wr(`REG_UCAST_HI, {16'h0, ucast_s[47:32]});
    wr(`REG_SRC_LO, src_s[31:0]);
    wr(`REG_SRC_HI, {16'h0, src_s[47:32]});
    // Every class once, then a bad frame that must change nothing
    for (int i = 0; i < 9; i++) begin
      q = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      run(`PAUSE_MCAST, src_s, `CTL_ETYPE, i == 8 ? `OPC_GLOBAL : `OPC_PRIO,
        i == 8 ? 16'hbeef : 16'h1 << i, q, 1'b0);
    end
    run(`PAUSE_MCAST, src_s, `CTL_ETYPE, `OPC_GLOBAL, 16'h0042, q, 1'b1);
    clear_all;
    for (int n = 0; n < 80; n++) begin
      ctrl_s = 12'($urandom) | (n % 4 != 0 ? 12'h3 : 12'h0);
      wr(`REG_CTRL, {20'h0, ctrl_s});
      if (n % 5 == 0) begin
        rxen_s = 9'($urandom);
        wr(`REG_RXEN, {23'h0, rxen_s});
      end
      q = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      run($urandom % 2 ? `PAUSE_MCAST : ($urandom % 2 ? ucast_s : 48'($urandom)),
        $urandom % 4 ? src_s : ~src_s, $urandom % 4 ? `CTL_ETYPE : 16'($urandom),
        $urandom % 2 ? `OPC_GLOBAL : ($urandom % 4 ? `OPC_PRIO : 16'($urandom)),
        16'($urandom), q, $urandom % 8 == 0);
      if (n % 7 == 6) clear_all;
    end
    apb(1'b0, `REG_QUANTA0, 32'h0, r, e);
    chk(r, 32'(qm[0]));
    // Raw requests stay pending even where the class enable hides them
    apb(1'b0, `REG_STATUS, 32'h0, r, e);
    chk(r, 32'(acc));
    apb(1'b0, `REG_DROPS, 32'h0, r, e);
    chk(r, 32'(drops));
    stop_test;
  end
endmodule
